//--- rtl/exec_defs.svh
// Constants for the instruction execution block
//
// Overview of operation
// - Second pre-clear after first clears watchdog and flags
// - Lone pre-clear only records that it ran
// - Complement writes inverted byte back, zero flag
// - Complement to accumulator, memory untouched, zero flag
// - Low nibble gains 6 when above 9 or aux carry
// - High nibble plus carry adjusted, sets carry flag
// - Decimal adjust result to memory, carry only
// - Memory increment or decrement modulo 256, zero flag
// - Increment or decrement into accumulator, zero flag
// - Halt stops execution, keeps state, pc plus one
// - Halt clears watchdog, sets powerdown, clears timeout
// - Direct jump loads pc from instruction field
// - Move memory to accumulator, no flags
// - Move immediate into accumulator, no flags
// - Move accumulator to memory, no flags
// - No-operation only advances the program counter
// - OR into accumulator, zero flag only
// - OR into memory byte, zero flag only
// - Plain return pops pc, two cycles
// - Return with value pops pc, loads accumulator
// - Interrupt return pops pc, sets global enable
// - Watchdog clear resets counter and both flags
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define OFF_INSTR  8'h00
`define OFF_ACC    8'h04
`define OFF_STATUS 8'h08
`define OFF_PC     8'h0c
`define OFF_WDT    8'h10
`define OFF_INTERRUPT_CONTROL_REG   8'h14
`define OFF_MADDR  8'h18
`define OFF_MDATA  8'h1c
`define OFF_STACK  8'h20

// ********************************************************
// Status bit positions
// ********************************************************
`define ST_C    0
`define ST_AC   1
`define ST_Z    2
`define ST_OV   3
`define ST_PD   4
`define ST_TO   5
`define ST_TC1  6
`define ST_TC2  7
`define ST_PRE1 8
`define ST_PRE2 9
`define ST_BUSY 10
`define ST_HALT 11
`define INTERRUPT_CONTROL_REG_GIE 0

// ********************************************************
// Sizes, reset values and arithmetic constants
// ********************************************************
`define MEM_AW    6
`define MEM_DEPTH 64
`define PC_W      10
`define SP_W      2
`define STK_DEPTH 4
`define ZERO8     8'h00
`define ONE8      8'h01
`define PC_RST    10'h000
`define PC_ONE    10'h001
`define BCD_MAX   5'h09
`define BCD_ADJ   5'h06
`define CNT_MAX   8'hff

`endif

//--- rtl/exec_pkg.sv
// Types shared by the instruction execution block
package exec_pkg;

  typedef enum logic [4:0] {
    no_operation_op          = 5'h00,
    watchdog_clear_op        = 5'h01,
    watchdog_preclear_first  = 5'h02,
    watchdog_preclear_second = 5'h03,
    complement_op            = 5'h04,
    complement_to_acc_op     = 5'h05,
    decimal_adjust_op        = 5'h06,
    decrement_op             = 5'h07,
    decrement_to_acc_op      = 5'h08,
    increment_op             = 5'h09,
    increment_to_acc_op      = 5'h0a,
    halt_op                  = 5'h0b,
    direct_jump_op           = 5'h0c,
    move_mem_to_acc_op       = 5'h0d,
    move_imm_op              = 5'h0e,
    move_acc_to_mem_op       = 5'h0f,
    or_mem_op                = 5'h10,
    or_imm_op                = 5'h11,
    bitwise_or_to_mem_op     = 5'h12,
    subroutine_return_op     = 5'h13,
    return_value_op          = 5'h14,
    interrupt_return_op      = 5'h15
  } op_e;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_busy = 3'b010,
    st_halt = 3'b100
  } state_e;

  typedef struct packed {
    logic       wake;
    logic [4:0] rsv2;
    logic [1:0] tgt_hi;
    logic [7:0] imm;
    logic       rsv1;
    logic [6:0] maddr;
    logic [2:0] rsv0;
    op_e        op;
  } instr_s;

endpackage

//--- rtl/exec_core.sv
// Instruction execution subset with an AHB-Lite register port
`include "exec_defs.svh"

module exec_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             clk_stop,
  output logic             global_irq_enable
);
  import exec_pkg::*;

  // ******************************************************
  // Bus slave
  // ******************************************************
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic [31:0] rd_mux;
  logic        ap;

  assign ap = hsel & htrans[1] & hready;

  // Reads take one wait state so the returned word reflects
  // a write committed in the data phase just before
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      addr_q      <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (ce) begin
      if (ap) begin
        wr_q        <= hwrite;
        rd_q        <= ~hwrite;
        addr_q      <= haddr[7:0];
        hreadyout_q <= hwrite;
      end else begin
        wr_q <= 1'b0;
        if (rd_q) begin
          rd_q        <= 1'b0;
          hrdata_q    <= rd_mux;
          hreadyout_q <= 1'b1;
        end
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  logic w_instr;
  logic w_acc;
  logic w_status;
  logic w_pc;
  logic w_interrupt_control_reg;
  logic w_maddr;
  logic w_mdata;
  logic w_stack;

  assign w_instr  = wr_q && (addr_q == `OFF_INSTR);
  assign w_acc    = wr_q && (addr_q == `OFF_ACC);
  assign w_status = wr_q && (addr_q == `OFF_STATUS);
  assign w_pc     = wr_q && (addr_q == `OFF_PC);
  assign w_interrupt_control_reg   = wr_q && (addr_q == `OFF_INTERRUPT_CONTROL_REG);
  assign w_maddr  = wr_q && (addr_q == `OFF_MADDR);
  assign w_mdata  = wr_q && (addr_q == `OFF_MDATA);
  assign w_stack  = wr_q && (addr_q == `OFF_STACK);

  // ******************************************************
  // Core state
  // ******************************************************
  state_e                st_q;
  logic [7:0]            acc_q;
  logic                  c_q;
  logic                  ac_q;
  logic                  z_q;
  logic                  ov_q;
  logic                  tc1_q;
  logic                  tc2_q;
  logic                  pd_q;
  logic                  to_q;
  logic                  pre1_q;
  logic                  pre2_q;
  logic [7:0]            wdt_q;
  logic [7:0]            presc_q;
  logic [`PC_W-1:0]      pc_q;
  logic [`SP_W-1:0]      sp_q;
  logic [`PC_W-1:0]      stack_q [`STK_DEPTH];
  logic [7:0]            mem [`MEM_DEPTH];
  logic [`MEM_AW-1:0]    maddr_q;
  logic                  gie_q;

  instr_s                ins;
  logic                  go;
  logic [`MEM_AW-1:0]    ma;
  logic [7:0]            m;
  logic [7:0]            res;
  logic                  to_acc;
  logic                  to_mem;
  logic                  upd_z;
  logic                  is_ret;
  logic [`SP_W-1:0]      sp_pop;

  assign ins    = instr_s'(hwdata);
  assign go     = w_instr && (st_q == st_idle);
  assign ma     = ins.maddr[`MEM_AW-1:0];
  assign m      = mem[ma];
  assign sp_pop = sp_q - 1'b1;
  assign is_ret = (ins.op == subroutine_return_op) ||
                  (ins.op == return_value_op) ||
                  (ins.op == interrupt_return_op);

  // ******************************************************
  // Decimal adjust
  // ******************************************************
  logic [4:0] lo_sum;
  logic       ac1;
  logic [4:0] hi_in;
  logic [4:0] hi_sum;
  logic       daa_c;
  logic [7:0] daa_res;

  always_comb begin
    lo_sum = {1'b0, acc_q[3:0]};
    if (lo_sum > `BCD_MAX || ac_q) begin
      lo_sum = lo_sum + `BCD_ADJ;
    end
    ac1   = lo_sum[4];
    hi_in = {1'b0, acc_q[7:4]} + {4'h0, ac1};
    if (hi_in > `BCD_MAX || c_q) begin
      hi_sum = hi_in + `BCD_ADJ;
      daa_c  = 1'b1;
    end else begin
      hi_sum = hi_in;
      daa_c  = c_q;
    end
    daa_res = {hi_sum[3:0], lo_sum[3:0]};
  end

  // ******************************************************
  // Data path select
  // ******************************************************
  always_comb begin
    res    = `ZERO8;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z  = 1'b0;
    unique case (ins.op)
      complement_op: begin
        res = ~m;
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      complement_to_acc_op: begin
        res = ~m;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      decimal_adjust_op: begin
        res = daa_res;
        to_mem = 1'b1;
      end
      decrement_op: begin
        res = m - `ONE8;
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      increment_op: begin
        res = m + `ONE8;
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      decrement_to_acc_op: begin
        res = m - `ONE8;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      increment_to_acc_op: begin
        res = m + `ONE8;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      move_mem_to_acc_op: begin
        res = m;
        to_acc = 1'b1;
      end
      move_imm_op, return_value_op: begin
        res = ins.imm;
        to_acc = 1'b1;
      end
      move_acc_to_mem_op: begin
        res = acc_q;
        to_mem = 1'b1;
      end
      or_mem_op: begin
        res = acc_q | m;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      or_imm_op: begin
        res = acc_q | ins.imm;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      bitwise_or_to_mem_op: begin
        res = acc_q | m;
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      default: begin
        res = `ZERO8;
      end
    endcase
  end

  // ******************************************************
  // Sequencing
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= st_idle;
    end else if (ce) begin
      unique case (st_q)
        st_idle: begin
          if (go && ins.op == halt_op) begin
            st_q <= st_halt;
          end else if (go && is_ret) begin
            st_q <= st_busy;
          end
        end
        st_busy: begin
          st_q <= st_idle;
        end
        st_halt: begin
          // Only an explicit wake write resumes execution
          if (w_instr && ins.wake) begin
            st_q <= st_idle;
          end
        end
        default: begin
          st_q <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= `ZERO8;
    end else if (ce) begin
      if (go && to_acc) begin
        acc_q <= res;
      end else if (w_acc) begin
        acc_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_q   <= 1'b0;
      ac_q  <= 1'b0;
      z_q   <= 1'b0;
      ov_q  <= 1'b0;
      tc1_q <= 1'b0;
      tc2_q <= 1'b0;
    end else if (ce) begin
      if (go) begin
        if (upd_z) begin
          z_q <= (res == `ZERO8);
        end
        if (ins.op == decimal_adjust_op) begin
          c_q <= daa_c;
        end
      end else if (w_status) begin
        c_q   <= hwdata[`ST_C];
        ac_q  <= hwdata[`ST_AC];
        z_q   <= hwdata[`ST_Z];
        ov_q  <= hwdata[`ST_OV];
        tc1_q <= hwdata[`ST_TC1];
        tc2_q <= hwdata[`ST_TC2];
      end
    end
  end

  // Data memory has no reset; software initialises it
  always_ff @(posedge hclk) begin
    if (ce) begin
      if (go && to_mem) begin
        mem[ma] <= res;
      end else if (w_mdata) begin
        mem[maddr_q] <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      maddr_q <= '0;
    end else if (ce && w_maddr) begin
      maddr_q <= hwdata[`MEM_AW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= `PC_RST;
    end else if (ce) begin
      if (go) begin
        if (ins.op == direct_jump_op) begin
          pc_q <= {ins.tgt_hi, ins.imm};
        end else if (is_ret) begin
          pc_q <= stack_q[sp_pop];
        end else begin
          pc_q <= pc_q + `PC_ONE;
        end
      end else if (w_pc) begin
        pc_q <= hwdata[`PC_W-1:0];
      end
    end
  end

  // Stack is filled by software writes; it wraps silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= '0;
    end else if (ce) begin
      if (go && is_ret) begin
        sp_q <= sp_pop;
      end else if (w_stack) begin
        sp_q <= sp_q + 1'b1;
      end
    end
  end

  for (genvar i = 0; i < `STK_DEPTH; i++) begin : g_stack
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stack_q[i] <= `PC_RST;
      end else if (ce && w_stack && !go && sp_q == `SP_W'(i)) begin
        stack_q[i] <= hwdata[`PC_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_q <= 1'b0;
    end else if (ce) begin
      if (go && ins.op == interrupt_return_op) begin
        gie_q <= 1'b1;
      end else if (w_interrupt_control_reg) begin
        gie_q <= hwdata[`INTERRUPT_CONTROL_REG_GIE];
      end
    end
  end

  // ******************************************************
  // Watchdog and power flags
  // ******************************************************
  logic wdt_clr;
  logic pre_pair;

  assign pre_pair =
    (ins.op == watchdog_preclear_second && pre1_q) ||
    (ins.op == watchdog_preclear_first && pre2_q);
  assign wdt_clr = go && (ins.op == watchdog_clear_op || pre_pair);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_q   <= `ZERO8;
      presc_q <= `ZERO8;
      pd_q    <= 1'b0;
      to_q    <= 1'b0;
      pre1_q  <= 1'b0;
      pre2_q  <= 1'b0;
    end else if (ce) begin
      if (go && ins.op == halt_op) begin
        wdt_q   <= `ZERO8;
        presc_q <= `ZERO8;
        pd_q    <= 1'b1;
        to_q    <= 1'b0;
      end else if (wdt_clr) begin
        wdt_q   <= `ZERO8;
        presc_q <= `ZERO8;
        pd_q    <= 1'b0;
        to_q    <= 1'b0;
        pre1_q  <= 1'b0;
        pre2_q  <= 1'b0;
      end else begin
        if (go && ins.op == watchdog_preclear_first) begin
          pre1_q <= 1'b1;
        end
        if (go && ins.op == watchdog_preclear_second) begin
          pre2_q <= 1'b1;
        end
        // Frozen in halt since the system clock is off there
        if (st_q != st_halt) begin
          presc_q <= presc_q + `ONE8;
          if (presc_q == `CNT_MAX) begin
            wdt_q <= wdt_q + `ONE8;
            if (wdt_q == `CNT_MAX) begin
              to_q <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ******************************************************
  // Read-back and outputs
  // ******************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      `OFF_ACC:    rd_mux[7:0] = acc_q;
      `OFF_STATUS: rd_mux[11:0] = {st_q == st_halt, st_q == st_busy,
                                   pre2_q, pre1_q, tc2_q, tc1_q,
                                   to_q, pd_q, ov_q, z_q, ac_q, c_q};
      `OFF_PC:     rd_mux[`PC_W-1:0] = pc_q;
      `OFF_WDT:    rd_mux[7:0] = wdt_q;
      `OFF_INTERRUPT_CONTROL_REG:   rd_mux[`INTERRUPT_CONTROL_REG_GIE] = gie_q;
      `OFF_MADDR:  rd_mux[`MEM_AW-1:0] = maddr_q;
      `OFF_MDATA:  rd_mux[7:0] = mem[maddr_q];
      `OFF_STACK:  rd_mux[`SP_W-1:0] = sp_q;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_stop          <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (ce) begin
      clk_stop          <= (st_q == st_halt);
      global_irq_enable <= gie_q;
    end
  end

endmodule // exec_core

//--- test/exec_core_monitor.sv
// Bus and pin checker for the instruction execution block
module exec_core_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        clk_stop,
  input wire logic        global_irq_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tk;
  logic       cm;
  logic       wi_q;
  logic       wn_q;
  logic [2:0] wk_q;
  logic [2:0] en_q;

  // ********************************************************
  // Helper: instruction and enable writes in their data phase
  // ********************************************************
  assign tk = hsel & htrans[1] & hready & ce;
  assign cm = wi_q & ce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wi_q <= 1'b0;
      wn_q <= 1'b0;
    end else if (ce) begin
      wi_q <= tk & hwrite & (haddr[7:0] == 8'h00);
      wn_q <= tk & hwrite & (haddr[7:0] == 8'h14);
    end
  end

  // Short history so a lagging pin can be traced to its cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wk_q <= 3'h0;
      en_q <= 3'h0;
    end else begin
      wk_q <= {wk_q[1:0], cm & hwdata[31]};
      en_q <= {en_q[1:0], (cm & (hwdata[4:0] == 5'h15)) |
               (wn_q & ce & hwdata[0])};
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  chk_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_fast: assert property (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("hrdata changed outside a read");
  chk_ce_freeze: assert property (!ce |=>
    $stable({hrdata, hreadyout, clk_stop, global_irq_enable}))
    else $error("state moved with ce low");
  chk_halt_stop: assert property (cm && hwdata[4:0] == 5'h0b && !clk_stop
    |-> ##[1:3] clk_stop) else $error("halt did not stop clock");
  chk_halt_hold: assert property ($fell(clk_stop) |-> (|wk_q))
    else $error("clock restarted without wake");
  chk_wake_run: assert property (cm && hwdata[31] && clk_stop
    |-> ##[1:3] !clk_stop) else $error("wake ignored");
  chk_interrupt_return_op_irq: assert property (cm && hwdata[4:0] == 5'h15 && !clk_stop
    |-> ##[1:3] global_irq_enable) else $error("interrupt_return_op left irq off");
  chk_irq_cause: assert property ($rose(global_irq_enable) |-> (|en_q))
    else $error("irq enable rose without cause");

  cov_read: cover property (tk && !hwrite);
  cov_halt: cover property ($rose(clk_stop));
  cov_interrupt_return_op: cover property ($rose(global_irq_enable));
  cov_ce: cover property (!ce);
endmodule // exec_core_monitor

//--- test/exec_core_tb.sv
// Register-level testbench for the instruction execution block
`include "exec_defs.svh"

module exec_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;

  typedef struct {
    op_e        op;
    logic [3:0] si, so;
    logic [7:0] a, m, im, ea, em;
  } vec_s;

  logic        hclk, hresetn, ce, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, clk_stop, global_irq_enable;
  int          error_cnt, checks;
  // Flags in [3:0] are OV Z AC C
  vec_s tv [17] = '{
    '{complement_op,4'hf,4'hb,8'h00,8'h5a,8'h00,8'h00,8'ha5},
    '{complement_op,4'h0,4'h4,8'h00,8'hff,8'h00,8'h00,8'h00},
    '{complement_to_acc_op,4'h0,4'h4,8'h11,8'hff,8'h00,8'h00,8'hff},
    '{decimal_adjust_op,4'h0,4'h1,8'h9a,8'h00,8'h00,8'h9a,8'h00},
    '{decimal_adjust_op,4'h2,4'h2,8'h45,8'h00,8'h00,8'h45,8'h4b},
    '{decimal_adjust_op,4'hd,4'hd,8'h29,8'h00,8'h00,8'h29,8'h89},
    '{decrement_op,4'h4,4'h0,8'h00,8'h00,8'h00,8'h00,8'hff},
    '{increment_op,4'h9,4'hd,8'h00,8'hff,8'h00,8'h00,8'h00},
    '{decrement_to_acc_op,4'h0,4'h4,8'h77,8'h01,8'h00,8'h00,8'h01},
    '{increment_to_acc_op,4'h4,4'h0,8'h00,8'h7f,8'h00,8'h80,8'h7f},
    '{move_mem_to_acc_op,4'hf,4'hf,8'h00,8'hc3,8'h00,8'hc3,8'hc3},
    '{move_imm_op,4'h0,4'h0,8'h55,8'h12,8'h00,8'h00,8'h12},
    '{move_acc_to_mem_op,4'h0,4'h0,8'h00,8'h77,8'h00,8'h00,8'h00},
    '{or_mem_op,4'h4,4'h0,8'h0f,8'hf0,8'h00,8'hff,8'hf0},
    '{or_imm_op,4'h0,4'h4,8'h00,8'h5a,8'h00,8'h00,8'h5a},
    '{bitwise_or_to_mem_op,4'hf,4'hb,8'h01,8'h80,8'h00,8'h01,8'h81},
    '{no_operation_op,4'ha,4'ha,8'h3c,8'hc5,8'h00,8'h3c,8'hc5}};

  exec_core exec_core_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .clk_stop(clk_stop),
    .global_irq_enable(global_irq_enable));

  // ********************************************************
  // Bus tasks
  // ********************************************************
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Samples ready before the edge, so the edge's own update cannot race
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    int   n;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 64);
    if (r !== 1'b1) begin
      check("bus wait", 32'h0, 32'h1);
      end_of_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] x;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy(x);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] m, e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(nm, x & m, e);
  endtask

  task automatic ex(input op_e op, input logic [7:0] im,
                    input logic [1:0] th, input logic wk);
    wr(`OFF_INSTR, instr_s'{wk, 5'h0, th, im, 1'b0, 7'h25, 3'h0, op});
  endtask

  // True when the watchdog count has moved past one
  task automatic wdt_big(input string nm, input logic big);
    bus(1'b0, `OFF_WDT, 32'h0, v);
    check(nm, {31'h0, v[7:0] > 8'h01}, {31'h0, big});
  endtask

  // Lets the watchdog run, with a short clock-enable pause
  task automatic run_wdt();
    repeat (300) @(posedge hclk);
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    ce <= 1'b1;
    repeat (300) @(posedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    {hresetn, ce, hsel, hwrite, htrans} = 6'b010000;
    {haddr, hwdata} = 64'h0;
    hsize = 3'b010;
    error_cnt = 0;
    checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd("pc rst", `OFF_PC, 32'h3ff, 32'h0);
    rd("st rst", `OFF_STATUS, 32'hfff, 32'h0);
    check("irq rst", {31'h0, global_irq_enable}, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
    foreach (tv[i]) begin
      wr(`OFF_STATUS, {28'h0, tv[i].si});
      wr(`OFF_ACC, {24'h0, tv[i].a});
      wr(`OFF_MADDR, 32'h0000_0025);
      wr(`OFF_MDATA, {24'h0, tv[i].m});
      wr(`OFF_PC, 32'h0000_01f0);
      ex(tv[i].op, tv[i].im, 2'b00, 1'b0);
      rd("acc", `OFF_ACC, 32'hff, {24'h0, tv[i].ea});
      rd("mem", `OFF_MDATA, 32'hff, {24'h0, tv[i].em});
      rd("flags", `OFF_STATUS, 32'hf, {28'h0, tv[i].so});
      rd("pc", `OFF_PC, 32'h3ff, 32'h1f1);
    end
    wr(`OFF_PC, 32'h0000_00aa);
    run_wdt();
    wdt_big("wdt runs", 1'b1);
    ex(halt_op, 8'h00, 2'b00, 1'b0);
    rd("halt st", `OFF_STATUS, 32'h830, 32'h810);
    rd("halt wdt", `OFF_WDT, 32'hff, 32'h0);
    check("stop", {31'h0, clk_stop}, 32'h1);
    ex(no_operation_op, 8'h00, 2'b00, 1'b0);
    rd("halt pc", `OFF_PC, 32'h3ff, 32'h0ab);
    ex(no_operation_op, 8'h00, 2'b00, 1'b1);
    rd("wake st", `OFF_STATUS, 32'h830, 32'h010);
    run_wdt();
    ex(watchdog_preclear_first, 8'h00, 2'b00, 1'b0);
    rd("pre1 st", `OFF_STATUS, 32'h330, 32'h110);
    wdt_big("pre1 wdt", 1'b1);
    ex(watchdog_preclear_second, 8'h00, 2'b00, 1'b0);
    rd("pre2 st", `OFF_STATUS, 32'h330, 32'h0);
    wdt_big("pre2 wdt", 1'b0);
    ex(halt_op, 8'h00, 2'b00, 1'b0);
    ex(no_operation_op, 8'h00, 2'b00, 1'b1);
    ex(watchdog_preclear_second, 8'h00, 2'b00, 1'b0);
    rd("lone st", `OFF_STATUS, 32'h330, 32'h210);
    run_wdt();
    ex(watchdog_clear_op, 8'h00, 2'b00, 1'b0);
    rd("clr st", `OFF_STATUS, 32'h330, 32'h0);
    wdt_big("watchdog_clear_op", 1'b0);
    wr(`OFF_STATUS, 32'h0000_0001);
    wr(`OFF_STACK, 32'h0000_02a5);
    wr(`OFF_STACK, 32'h0000_0133);
    rd("sp", `OFF_STACK, 32'h3, 32'h2);
    ex(subroutine_return_op, 8'h00, 2'b00, 1'b0);
    rd("ret pc", `OFF_PC, 32'h3ff, 32'h133);
    ex(return_value_op, 8'h00, 2'b00, 1'b0);
    rd("retv pc", `OFF_PC, 32'h3ff, 32'h2a5);
    rd("retv acc", `OFF_ACC, 32'hff, 32'h0);
    wr(`OFF_INTERRUPT_CONTROL_REG, 32'h0);
    wr(`OFF_STACK, 32'h0000_00ff);
    ex(interrupt_return_op, 8'h00, 2'b00, 1'b0);
    rd("interrupt_return_op pc", `OFF_PC, 32'h3ff, 32'h0ff);
    rd("interrupt_control_reg", `OFF_INTERRUPT_CONTROL_REG, 32'h1, 32'h1);
    check("irq pin", {31'h0, global_irq_enable}, 32'h1);
    ex(direct_jump_op, 8'h5c, 2'b10, 1'b0);
    rd("jmp pc", `OFF_PC, 32'h3ff, 32'h25c);
    rd("ret st", `OFF_STATUS, 32'hf, 32'h1);
    end_of_test();
  end
endmodule // exec_core_tb

bind exec_core exec_core_monitor exec_core_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .clk_stop(clk_stop), .global_irq_enable(global_irq_enable));
